// >>> logic/spi_stat_pkg.sv
// constants shared by the spi status and interrupt logic
// assumes a 32-bit axi4-lite register bus and one 125 mhz clock
package spi_stat_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [23:0] RXDATA_ADDR   = 24'h30_1700;
  localparam logic [23:0] TXDATA_ADDR   = 24'h30_1704;
  localparam logic [23:0] STATUS_ADDR   = 24'h30_1714;
  localparam logic [23:0] IRQCTL_ADDR   = 24'h30_1718;
  localparam logic [23:0] EVSTAT_ADDR   = 24'h30_1720;
  localparam logic [23:0] EVMASK_ADDR   = 24'h30_1724;
  localparam logic [23:0] MODE_ADDR     = 24'h30_1728;

  // ****************************************
  // status field positions
  // ****************************************
  localparam int BUSY_BIT     = 6;
  localparam int TXEMPTY_BIT  = 4;
  localparam int OVERRUN_BIT  = 3;
  localparam int RXFULL_BIT   = 2;

  // ****************************************
  // interrupt control field positions
  // ****************************************
  localparam int TXE_IE_BIT   = 4;
  localparam int OVR_IE_BIT   = 3;
  localparam int RXF_IE_BIT   = 2;
  localparam int MANUAL_BIT   = 1;
  localparam int IRQ_OE_BIT   = 0;
  localparam logic [4:0] IRQCTL_WMASK = 5'h1F;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [4:0] IRQCTL_RESET = 5'h00;
  localparam logic       TXEMPTY_RESET = 1'b1;

  // event register layout: one bit per source event
  localparam int EV_TXE = 0;
  localparam int EV_OVR = 1;
  localparam int EV_RXF = 2;
  localparam int EV_N   = 3;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> logic/spi_axil_port.sv
// axi4-lite slave front end: one write and one read at a time
// assumes the master holds payloads until taken; no stalls from the core
`timescale 1ns/1ps
`default_nettype none
module spi_axil_port (
  input  wire logic        clk,      // system clock
  input  wire logic        srst,     // sync reset, active high
  input  wire logic [23:0] awaddr,   // write address
  input  wire logic        awvalid,  // write address valid
  output logic             awready,  // write address ready
  input  wire logic [31:0] wdata,    // write data
  input  wire logic        wvalid,   // write data valid
  output logic             wready,   // write data ready
  output logic [1:0]       bresp,    // write response
  output logic             bvalid,   // write response valid
  input  wire logic        bready,   // write response ready
  input  wire logic [23:0] araddr,   // read address
  input  wire logic        arvalid,  // read address valid
  output logic             arready,  // read address ready
  output logic [31:0]      rdata,    // read data
  output logic [1:0]       rresp,    // read response
  output logic             rvalid,   // read response valid
  input  wire logic        rready,   // read response ready
  output logic             wr_go,    // one-cycle write strobe
  output logic [23:0]      wr_addr,  // write address to core
  output logic [31:0]      wr_data,  // write data to core
  input  wire logic        wr_err,   // core reports unmapped write
  output logic             rd_go,    // one-cycle read strobe
  output logic [23:0]      rd_addr,  // read address to core
  input  wire logic [31:0] rd_val,   // read value from core
  input  wire logic        rd_err    // core reports unmapped read
);

  logic        aw_have_q, w_have_q;
  logic [23:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic        bvalid_q, rvalid_q, rd_pend_q;
  logic [1:0]  bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ****************************************
  // handshakes
  // ****************************************
  // address and data are latched separately so either may come first
  assign awready = !aw_have_q && !bvalid_q;
  assign wready  = !w_have_q && !bvalid_q;
  assign arready = !rd_pend_q && !rvalid_q;
  assign wr_go   = aw_have_q && w_have_q && !bvalid_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign rd_go   = rd_pend_q;
  assign rd_addr = araddr_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;

  // write channel
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= spi_stat_pkg::RESP_OKAY;
      awaddr_q  <= 24'h00_0000;
      wdata_q   <= 32'h0000_0000;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= wdata;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_err ? spi_stat_pkg::RESP_SLVERR
                            : spi_stat_pkg::RESP_OKAY;
      end else if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: value is sampled in the cycle after the address
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_pend_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= spi_stat_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      araddr_q  <= 24'h00_0000;
    end else begin
      if (arvalid && arready) begin
        rd_pend_q <= 1'b1;
        araddr_q  <= araddr;
      end
      if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_val;
        rresp_q   <= rd_err ? spi_stat_pkg::RESP_SLVERR
                            : spi_stat_pkg::RESP_OKAY;
      end else if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// >>> logic/spi_busy_track.sv
// busy tracker for one spi transfer including wait cycles
// assumes start and done pulses come from the shift and wait logic
`timescale 1ns/1ps
`default_nettype none
module spi_busy_track (
  input  wire logic clk,       // system clock
  input  wire logic srst,      // sync reset, active high
  input  wire logic master,    // master mode select
  input  wire logic xfer_go,   // transfer begins, one cycle
  input  wire logic xfer_end,  // transfer and wait ended, one cycle
  output logic      busy       // busy flag
);

  logic busy_q, busy_d;

  // start wins over end so a back to back transfer stays busy
  assign busy_d = xfer_go ? 1'b1 : (xfer_end ? 1'b0 : busy_q);

  always_ff @(posedge clk) begin
    if (srst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // slave mode hides the flag entirely
  assign busy = busy_q && master;

endmodule
`default_nettype wire

// >>> logic/spi_status_irq.sv
// status flags and interrupt request logic of the spi controller
// assumes datapath strobes are on CLK; bus is axi4-lite, 32-bit words
// Notes on behaviour
// - master busy rises at transfer start, holds through waits, falls at end
// - slave mode forces busy to zero always
// - tx write clears tx-empty; load to shift register sets it
// - after reset tx-empty is one; busy, overrun, rx-full are zero
// - rx load while rx-full still set raises overrun
// - reading rx data register clears overrun
// - rx load sets rx-full; reading rx data clears it
// - tx-empty enable gates request on tx load into shift register
// - overrun enable gates request on overrun event
// - rx-full enable gates request on rx load
// - manual bit with output enable raises request and pending flag
// - manual bit cleared withdraws request; pending flag stays latched
// - output enable zero blocks every request including manual
// - all sources share one pending flag set on enabled event
// - master uses internal shift clock; slave uses external clock
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module spi_status_irq (
  input  wire logic        CLK,        // spi module clock, 125 mhz
  input  wire logic        SRST,       // sync reset, active high
  input  wire logic [23:0] AWADDR,     // axi write address
  input  wire logic        AWVALID,    // axi write address valid
  output logic             AWREADY,    // axi write address ready
  input  wire logic [31:0] WDATA,      // axi write data
  input  wire logic [3:0]  WSTRB,      // axi byte strobes
  input  wire logic        WVALID,     // axi write data valid
  output logic             WREADY,     // axi write data ready
  output logic [1:0]       BRESP,      // axi write response
  output logic             BVALID,     // axi write response valid
  input  wire logic        BREADY,     // axi write response ready
  input  wire logic [23:0] ARADDR,     // axi read address
  input  wire logic        ARVALID,    // axi read address valid
  output logic             ARREADY,    // axi read address ready
  output logic [31:0]      RDATA,      // axi read data
  output logic [1:0]       RRESP,      // axi read response
  output logic             RVALID,     // axi read response valid
  input  wire logic        RREADY,     // axi read response ready
  input  wire logic        TX_LOAD,    // tx word moved to shifter, pulse
  input  wire logic        RX_LOAD,    // rx word moved to data reg, pulse
  input  wire logic        XFER_END,   // transfer and waits over, pulse
  input  wire logic [31:0] RX_WORD,    // received word from datapath
  output logic [31:0]      TX_WORD,    // word for the shifter
  output logic             MASTER,     // master mode select
  output logic             SHIFT_INT,  // shifter uses internal clock
  output logic             IRQ_REQ,    // request to interrupt controller
  output logic             IRQ         // level interrupt from event bits
);

  // ****************************************
  // bus front end
  // ****************************************
  logic        wr_go, rd_go, wr_err, rd_err;
  logic [23:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_val;

  spi_axil_port u_port (
    .clk     (CLK),
    .srst    (SRST),
    .awaddr  (AWADDR),
    .awvalid (AWVALID),
    .awready (AWREADY),
    .wdata   (WDATA),
    .wvalid  (WVALID),
    .wready  (WREADY),
    .bresp   (BRESP),
    .bvalid  (BVALID),
    .bready  (BREADY),
    .araddr  (ARADDR),
    .arvalid (ARVALID),
    .arready (ARREADY),
    .rdata   (RDATA),
    .rresp   (RRESP),
    .rvalid  (RVALID),
    .rready  (RREADY),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_err  (wr_err),
    .rd_go   (rd_go),
    .rd_addr (rd_addr),
    .rd_val  (rd_val),
    .rd_err  (rd_err)
  );

  // ****************************************
  // address decode
  // ****************************************
  // strobes kept from the data handshake; the master may drop them after
  logic full_word_q;
  wire w_tx   = wr_go && (wr_addr == spi_stat_pkg::TXDATA_ADDR);
  wire w_ictl = wr_go && (wr_addr == spi_stat_pkg::IRQCTL_ADDR);
  wire w_evs  = wr_go && (wr_addr == spi_stat_pkg::EVSTAT_ADDR);
  wire w_evm  = wr_go && (wr_addr == spi_stat_pkg::EVMASK_ADDR);
  wire w_mode = wr_go && (wr_addr == spi_stat_pkg::MODE_ADDR);
  assign wr_err = !(w_tx || w_ictl || w_evs || w_evm || w_mode);

  wire r_rx   = rd_addr == spi_stat_pkg::RXDATA_ADDR;
  wire r_stat = rd_addr == spi_stat_pkg::STATUS_ADDR;
  wire r_ictl = rd_addr == spi_stat_pkg::IRQCTL_ADDR;
  wire r_evs  = rd_addr == spi_stat_pkg::EVSTAT_ADDR;
  wire r_evm  = rd_addr == spi_stat_pkg::EVMASK_ADDR;
  wire r_mode = rd_addr == spi_stat_pkg::MODE_ADDR;
  assign rd_err = !(r_rx || r_stat || r_ictl || r_evs || r_evm || r_mode);
  // the read side effect happens once, on the read strobe
  wire rx_read = rd_go && r_rx;

  // ****************************************
  // registers
  // ****************************************
  logic [4:0]                  ictl_q;
  logic [spi_stat_pkg::EV_N-1:0] evst_q, evmk_q, ev_now;
  logic                        mode_q, txe_q, ovr_q, rxf_q, req_q;
  logic [31:0]                 tx_q, rx_q;
  logic                        busy;

  // control register and mode bit; reserved control bits are dropped
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ictl_q <= spi_stat_pkg::IRQCTL_RESET;
      mode_q <= 1'b0;
      evmk_q <= '0;
      full_word_q <= 1'b0;
    end else begin
      full_word_q <= (WVALID && WREADY) ? (WSTRB == 4'hF) : full_word_q;
      if (w_ictl && full_word_q) begin
        ictl_q <= wr_data[4:0] & spi_stat_pkg::IRQCTL_WMASK;
      end
      if (w_mode && full_word_q) begin
        mode_q <= wr_data[0];
      end
      if (w_evm && full_word_q) begin
        evmk_q <= wr_data[spi_stat_pkg::EV_N-1:0];
      end
    end
  end

  // transmit holding register and its empty flag
  always_ff @(posedge CLK) begin
    if (SRST) begin
      txe_q <= spi_stat_pkg::TXEMPTY_RESET;
      tx_q  <= 32'h0000_0000;
    end else begin
      if (w_tx && full_word_q) begin
        tx_q  <= wr_data;
        txe_q <= 1'b0;
      end else if (TX_LOAD) begin
        txe_q <= 1'b1;
      end
    end
  end

  // receive register, full and overrun flags; a load wins over a read for rx-full, a read still clears overrun
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rxf_q <= 1'b0;
      ovr_q <= 1'b0;
      rx_q  <= 32'h0000_0000;
    end else begin
      if (RX_LOAD) begin
        rx_q  <= RX_WORD;
        rxf_q <= 1'b1;
        if (rxf_q && !rx_read) begin
          ovr_q <= 1'b1;
        end else if (rx_read) begin
          ovr_q <= 1'b0;
        end
      end else if (rx_read) begin
        rxf_q <= 1'b0;
        ovr_q <= 1'b0;
      end
    end
  end

  // busy tracking: a transfer begins when a word enters the shifter
  spi_busy_track u_busy (
    .clk      (CLK),
    .srst     (SRST),
    .master   (mode_q),
    .xfer_go  (TX_LOAD),
    .xfer_end (XFER_END),
    .busy     (busy)
  );

  // ****************************************
  // interrupt request to the controller
  // ****************************************
  // events of this cycle; overrun is a load onto unread data
  assign ev_now[spi_stat_pkg::EV_TXE] = TX_LOAD;
  assign ev_now[spi_stat_pkg::EV_OVR] = RX_LOAD && rxf_q && !rx_read;
  assign ev_now[spi_stat_pkg::EV_RXF] = RX_LOAD;

  wire en_txe = ictl_q[spi_stat_pkg::TXE_IE_BIT] && TX_LOAD;
  wire en_ovr = ictl_q[spi_stat_pkg::OVR_IE_BIT]
                && ev_now[spi_stat_pkg::EV_OVR];
  wire en_rxf = ictl_q[spi_stat_pkg::RXF_IE_BIT] && RX_LOAD;
  wire manual = ictl_q[spi_stat_pkg::MANUAL_BIT];
  // the controller latches the pending flag, so dropping manual
  // only withdraws the level, never clears what was latched
  wire req_d  = ictl_q[spi_stat_pkg::IRQ_OE_BIT]
                && (en_txe || en_ovr || en_rxf || manual);

  // registered so the controller sees a clean synchronous request
  always_ff @(posedge CLK) begin
    if (SRST) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end
  assign IRQ_REQ = req_q;

  // ****************************************
  // sticky event bits, write one to clear
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < spi_stat_pkg::EV_N; gi++) begin : g_ev
      // a new event in the clearing cycle keeps the bit set
      always_ff @(posedge CLK) begin
        if (SRST) begin
          evst_q[gi] <= 1'b0;
        end else if (ev_now[gi]) begin
          evst_q[gi] <= 1'b1;
        end else if (w_evs && full_word_q && wr_data[gi]) begin
          evst_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign IRQ = |(evst_q & evmk_q);

  // ****************************************
  // outputs and read mux
  // ****************************************
  assign TX_WORD   = tx_q;
  assign MASTER    = mode_q;
  assign SHIFT_INT = mode_q;

  wire [31:0] stat_word = {25'h000_0000, busy, 1'b0, txe_q, ovr_q,
                           rxf_q, 2'h0};
  assign rd_val = r_rx   ? rx_q :
                  r_stat ? stat_word :
                  r_ictl ? {27'h000_0000, ictl_q} :
                  r_evs  ? {29'h0000_0000, evst_q} :
                  r_evm  ? {29'h0000_0000, evmk_q} :
                  r_mode ? {31'h0000_0000, mode_q} :
                  32'h0000_0000;

endmodule
`default_nettype wire

// >>> tb/spi_status_irq_monitor.sv
// checker for the spi status and interrupt block, on its ports only
// assumes one clock, sync reset, and control writes offered whole
`timescale 1ns/1ps
`default_nettype none
module spi_status_irq_monitor (
  input wire logic        CLK,       // clock
  input wire logic        SRST,      // sync reset
  input wire logic [23:0] AWADDR,    // write address
  input wire logic        AWVALID,   // address valid
  input wire logic        AWREADY,   // address ready
  input wire logic [31:0] WDATA,     // write data
  input wire logic [3:0]  WSTRB,     // byte strobes
  input wire logic        WVALID,    // data valid
  input wire logic        WREADY,    // data ready
  input wire logic        TX_LOAD,   // tx word to shifter
  input wire logic        RX_LOAD,   // rx word loaded
  input wire logic [31:0] TX_WORD,   // word for shifter
  input wire logic        MASTER,    // mode
  input wire logic        SHIFT_INT, // internal shift clock
  input wire logic        IRQ_REQ    // request out
);
  // ****************************************
  // shadow of the interrupt control bits
  // ****************************************
  logic [4:0] ctl_q, ctl_d;
  logic       wtake;
  // a write counts only when both channels go in one edge, full strobes
  assign wtake = AWVALID && AWREADY && WVALID && WREADY && WSTRB == 4'hF;
  assign ctl_d = (wtake && AWADDR == spi_stat_pkg::IRQCTL_ADDR) ?
                 WDATA[4:0] : ctl_q;
  // shadow runs one edge ahead of the design, hence the steady window
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ctl_q <= 5'h00;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  sequence s_ctl_steady;
    $stable(ctl_q) [*2];
  endsequence
  sequence s_tx_write;
    wtake && AWADDR == spi_stat_pkg::TXDATA_ADDR;
  endsequence

  property p_txe_req;
    s_ctl_steady ##0 (TX_LOAD && ctl_q[spi_stat_pkg::TXE_IE_BIT] &&
      ctl_q[spi_stat_pkg::IRQ_OE_BIT]) |-> ##[1:2] IRQ_REQ;
  endproperty
  a_txe_req: assert property (p_txe_req)
    else $error("tx load with enable gave no request");
  property p_rxf_req;
    s_ctl_steady ##0 (RX_LOAD && ctl_q[spi_stat_pkg::RXF_IE_BIT] &&
      ctl_q[spi_stat_pkg::IRQ_OE_BIT]) |-> ##[1:2] IRQ_REQ;
  endproperty
  a_rxf_req: assert property (p_rxf_req)
    else $error("rx load with enable gave no request");
  property p_gate_off;
    s_ctl_steady ##0 !ctl_q[spi_stat_pkg::IRQ_OE_BIT] |-> !IRQ_REQ;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("request with output enable off");
  property p_manual;
    s_ctl_steady ##0 (ctl_q[spi_stat_pkg::MANUAL_BIT] &&
      ctl_q[spi_stat_pkg::IRQ_OE_BIT]) |-> IRQ_REQ;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual request not issued");
  property p_withdraw;
    s_ctl_steady ##0 (ctl_q[4:1] == 4'h0) |-> !IRQ_REQ;
  endproperty
  a_withdraw: assert property (p_withdraw)
    else $error("request with no source enabled");
  property p_tx_word;
    s_tx_write |-> ##3 (TX_WORD == $past(WDATA, 3));
  endproperty
  a_tx_word: assert property (p_tx_word)
    else $error("tx word not taken from write");
  property p_shift_clk;
    SHIFT_INT == MASTER;
  endproperty
  a_shift_clk: assert property (p_shift_clk)
    else $error("shift clock source differs from mode");
  property p_quiet_reset;
    $past(SRST) |-> !IRQ_REQ;
  endproperty
  a_quiet_reset: assert property (p_quiet_reset)
    else $error("request right after reset");
endmodule

bind spi_status_irq spi_status_irq_monitor mon_u (
  .CLK(CLK), .SRST(SRST), .AWADDR(AWADDR), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
  .WREADY(WREADY), .TX_LOAD(TX_LOAD), .RX_LOAD(RX_LOAD),
  .TX_WORD(TX_WORD), .MASTER(MASTER), .SHIFT_INT(SHIFT_INT),
  .IRQ_REQ(IRQ_REQ)
);
`default_nettype wire

// >>> tb/irq_ctrl_model.sv
// host interrupt controller model: one shared pending flag
// assumes the request is sampled on the block clock
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_model (
  input  wire logic clk,     // clock
  input  wire logic srst,    // sync reset
  input  wire logic irq_req, // request from block
  input  wire logic clr,     // software acknowledge
  output logic      pending  // shared pending flag
);
  // only an acknowledge drops the flag, a withdrawn request does not
  always_ff @(posedge clk) begin
    if (srst) begin
      pending <= 1'b0;
    end else if (irq_req) begin
      pending <= 1'b1;
    end else if (clr) begin
      pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> tb/spi_status_irq_bench.sv
// self-checking bench for the spi status and interrupt block
// assumes the checker is bound in and the controller model beside it
`timescale 1ns/1ps
`default_nettype none
module spi_status_irq_bench;
  logic        clk = 1'b0, srst = 1'b1, pend_clr = 1'b0;
  logic [23:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rx_word = '0, rdata, tx_word;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        tx_load = 1'b0, rx_load = 1'b0, xfer_end = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        master, shift_int, irq_req, irq, pending;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb = 4'hF;
  int          failures = 0, comparisons = 0;

  always #4 clk = ~clk;

  spi_status_irq dut_u (
    .CLK(clk), .SRST(srst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .TX_LOAD(tx_load), .RX_LOAD(rx_load), .XFER_END(xfer_end),
    .RX_WORD(rx_word), .TX_WORD(tx_word), .MASTER(master),
    .SHIFT_INT(shift_int), .IRQ_REQ(irq_req), .IRQ(irq)
  );
  irq_ctrl_model irq_u (
    .clk(clk), .srst(srst), .irq_req(irq_req), .clr(pend_clr),
    .pending(pending)
  );

  // ****************************************
  // reporting
  // ****************************************
  task automatic complete_run;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // a bounded wait ran out: count it and stop
  task automatic hang;
    failures++;
    complete_run();
  endtask

  // ****************************************
  // bus and datapath drivers
  // ****************************************
  // sample handshakes at the falling edge, act after the next rising one
  task automatic wr(input logic [23:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ga, gw, gb = 1'b0;
    logic [1:0] rs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 40 && !gb; n++) begin
      @(negedge clk);
      ga = awvalid && awready;
      gw = wvalid && wready;
      gb = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ga) awvalid <= 1'b0;
      if (gw) wvalid <= 1'b0;
      if (gb) bready <= 1'b0;
    end
    if (!gb) hang();
    chk(32'(rs), 32'(er));
  endtask
  task automatic rd(input logic [23:0] a, output logic [31:0] d,
                    input logic [1:0] er);
    logic ga, gr = 1'b0;
    logic [1:0] rs;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 40 && !gr; n++) begin
      @(negedge clk);
      ga = arvalid && arready;
      gr = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
      if (ga) arvalid <= 1'b0;
      if (gr) rready <= 1'b0;
    end
    if (!gr) hang();
    chk(32'(rs), 32'(er));
  endtask
  task automatic rc(input logic [23:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v, spi_stat_pkg::RESP_OKAY);
    chk(v, e);
  endtask
  task automatic wo(input logic [23:0] a, input logic [31:0] d);
    wr(a, d, spi_stat_pkg::RESP_OKAY);
  endtask
  // expected status word from the four flags
  function automatic logic [31:0] st(input logic b, t, o, f);
    st = 32'h0000_0000;
    st[spi_stat_pkg::BUSY_BIT] = b;
    st[spi_stat_pkg::TXEMPTY_BIT] = t;
    st[spi_stat_pkg::OVERRUN_BIT] = o;
    st[spi_stat_pkg::RXFULL_BIT] = f;
  endfunction
  // k: 0 tx load, 1 rx load, 2 transfer end; one-cycle pulse
  task automatic pulse(input int k, input logic [31:0] w);
    @(posedge clk);
    rx_word <= w;
    tx_load <= (k == 0);
    rx_load <= (k == 1);
    xfer_end <= (k == 2);
    @(posedge clk);
    tx_load <= 1'b0;
    rx_load <= 1'b0;
    xfer_end <= 1'b0;
  endtask
  // k: 0 tx empty, 1 overrun, 2 rx full; drains the rx register after
  task automatic cause(input int k);
    logic [31:0] v;
    pulse(k == 0 ? 0 : 1, 32'h5A5A_0001);
    if (k == 1) pulse(1, 32'h5A5A_0002);
    rd(spi_stat_pkg::RXDATA_ADDR, v, spi_stat_pkg::RESP_OKAY);
  endtask
  // the flag is latched, so a fixed settle suffices either way
  task automatic pend_is(input logic e);
    repeat (6) @(posedge clk);
    chk(32'(pending), 32'(e));
  endtask
  task automatic pend_ack;
    @(posedge clk);
    pend_clr <= 1'b1;
    @(posedge clk);
    pend_clr <= 1'b0;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    logic [31:0] v;
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 1, 0, 0));
    wstrb <= 4'h1;
    wo(spi_stat_pkg::IRQCTL_ADDR, 32'h0000_0001);
    wstrb <= 4'hF;
    rc(spi_stat_pkg::IRQCTL_ADDR, 32'h0000_0000);
    rd(24'h30_1710, v, spi_stat_pkg::RESP_SLVERR);
  endtask
  task automatic t_busy;
    pulse(0, 32'h0000_0000);
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 1, 0, 0));
    pulse(2, 32'h0000_0000);
    wo(spi_stat_pkg::MODE_ADDR, 32'h0000_0001);
    wo(spi_stat_pkg::TXDATA_ADDR, 32'hA5C3_0F1E);
    @(negedge clk);
    chk({30'h0, shift_int, master}, 32'h0000_0003);
    chk(tx_word, 32'hA5C3_0F1E);
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 0, 0, 0));
    pulse(0, 32'h0000_0000);
    rc(spi_stat_pkg::STATUS_ADDR, st(1, 1, 0, 0));
    rc(spi_stat_pkg::STATUS_ADDR, st(1, 1, 0, 0));
    pulse(2, 32'h0000_0000);
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 1, 0, 0));
  endtask
  task automatic t_rx;
    pulse(1, 32'h1234_5678);
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 1, 0, 1));
    pulse(1, 32'h9ABC_DEF0);
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 1, 1, 1));
    rc(spi_stat_pkg::RXDATA_ADDR, 32'h9ABC_DEF0);
    rc(spi_stat_pkg::STATUS_ADDR, st(0, 1, 0, 0));
  endtask
  // each source alone with output enable, then with its enable cleared
  task automatic t_src;
    int k;
    for (k = 0; k < 3; k++) begin
      wo(spi_stat_pkg::IRQCTL_ADDR, (32'h0000_0010 >> k) | 32'h0000_0001);
      cause(k);
      pend_is(1'b1);
      pend_ack();
      wo(spi_stat_pkg::IRQCTL_ADDR, 32'h0000_0001);
      cause(k);
      pend_is(1'b0);
    end
  endtask
  task automatic t_man;
    wo(spi_stat_pkg::IRQCTL_ADDR, 32'h0000_0012);
    pulse(0, 32'h0000_0000);
    pend_is(1'b0);
    wo(spi_stat_pkg::IRQCTL_ADDR, 32'h0000_0003);
    pend_is(1'b1);
    wo(spi_stat_pkg::IRQCTL_ADDR, 32'h0000_0001);
    pend_is(1'b1);
    chk(32'(irq_req), 32'h0000_0000);
    pend_ack();
    pend_is(1'b0);
  endtask
  // level output: raise, mask, unmask, clear by writing one
  task automatic t_level;
    wo(spi_stat_pkg::EVSTAT_ADDR, 32'h0000_0007);
    wo(spi_stat_pkg::EVMASK_ADDR, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
    pulse(0, 32'h0000_0000);
    rc(spi_stat_pkg::EVSTAT_ADDR, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0001);
    wo(spi_stat_pkg::EVMASK_ADDR, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    wo(spi_stat_pkg::EVMASK_ADDR, 32'h0000_0001);
    wo(spi_stat_pkg::EVSTAT_ADDR, 32'h0000_0001);
    chk(32'(irq), 32'h0000_0000);
  endtask

  // main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_busy();
    t_rx();
    t_src();
    t_man();
    t_level();
    complete_run();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clk);
    hang();
  end
endmodule
`default_nettype wire
